/* File: glpc_pkg.sv */
package glpc_pkg;

   // Bus map of the port instances and the alternate-function unit.
   localparam logic [31:0] PORT_A_BASE   = 32'h4001_0800;
   localparam logic [31:0] PORT_B_BASE   = 32'h4001_0C00;
   localparam logic [31:0] PORT_STRIDE   = PORT_B_BASE - PORT_A_BASE;
   localparam logic [31:0] ALT_FN_BASE   = 32'h4001_0000;
   localparam logic [31:0] ALT_FN_SPAN   = 32'h0000_0400;
   localparam int          NUM_PORTS     = 5;
   localparam int          PINS_PER_PORT = 8;

   // Low-pin control register.
   localparam logic [31:0] CFG_LOW_OFS = 32'h0000_0000;
   localparam logic [31:0] CFG_LOW_RST = 32'h4444_4444;

   // Nibble layout: mode in the low pair, configuration in the high pair.
   localparam int NIBBLE_W = 4;
   localparam int FIELD_W  = 2;
   localparam int MODE_LSB = 0;
   localparam int CONF_LSB = 2;

   // Direction and speed codes.
   localparam logic [1:0] MODE_INPUT   = 2'h0;
   localparam logic [1:0] MODE_OUT_10M = 2'h1;
   localparam logic [1:0] MODE_OUT_2M  = 2'h2;
   localparam logic [1:0] MODE_OUT_50M = 2'h3;

   // Drive style codes, read against the mode.
   localparam logic [1:0] CONF_IN_ANALOG = 2'h0;
   localparam logic [1:0] CONF_IN_FLOAT  = 2'h1;
   localparam logic [1:0] CONF_IN_PULL   = 2'h2;
   localparam logic [1:0] CONF_OUT_PP    = 2'h0;
   localparam logic [1:0] CONF_OUT_OD    = 2'h1;
   localparam logic [1:0] CONF_OUT_AF    = 2'h2;

   typedef enum logic [7:0] {
      FN_ANALOG   = 8'h01,
      FN_IN_FLOAT = 8'h02,
      FN_IN_PULL  = 8'h04,
      FN_IN_RSVD  = 8'h08,
      FN_OUT_PP   = 8'h10,
      FN_OUT_OD   = 8'h20,
      FN_AF_OD    = 8'h40,
      FN_AF_PP    = 8'h80
   } glpc_pin_fn_t;

   typedef struct packed {
      glpc_pin_fn_t fn;
      logic [1:0]   speed;
   } glpc_pin_cfg_t;

   localparam glpc_pin_cfg_t PIN_RST_CFG = '{fn: FN_IN_FLOAT, speed: MODE_INPUT};

   typedef struct packed {
      logic [31:0] addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } glpc_bus_req_t;

endpackage : glpc_pkg

/* File: glpc_addr_dec.sv */
`timescale 1ns/10ps
module glpc_addr_dec #(
   parameter int NUM_PORTS = glpc_pkg::NUM_PORTS
) (
   // Address under decode
   input  wire logic [31:0]          addr_in,
   // Hits
   output wire logic [NUM_PORTS-1:0] port_hit_out,
   output wire logic                 alt_hit_out
);
   import glpc_pkg::*;

   function automatic logic [31:0] port_base(input int idx);
      return PORT_A_BASE + PORT_STRIDE * 32'(idx);
   endfunction : port_base

   wire logic [31:0] alt_rel = addr_in - ALT_FN_BASE;

   for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
      assign port_hit_out[p] = (addr_in == port_base(p) + CFG_LOW_OFS);
   end

   assign alt_hit_out = (alt_rel < ALT_FN_SPAN);

endmodule : glpc_addr_dec

/* File: glpc_pin_dec.sv */
`timescale 1ns/10ps
module glpc_pin_dec (
   // One pin's nibble
   input  wire logic [3:0]              nibble_in,
   // Decoded function and speed
   output glpc_pkg::glpc_pin_cfg_t      cfg_out
);
   import glpc_pkg::*;

   function automatic glpc_pin_fn_t decode_fn(input logic [1:0] mode, input logic [1:0] conf);
      glpc_pin_fn_t fn;
      fn = FN_IN_FLOAT;
      if (mode == MODE_INPUT) begin
         case (conf)
            CONF_IN_ANALOG: fn = FN_ANALOG;
            CONF_IN_FLOAT:  fn = FN_IN_FLOAT;
            CONF_IN_PULL:   fn = FN_IN_PULL;
            default:        fn = FN_IN_RSVD;
         endcase
      end else begin
         case (conf)
            CONF_OUT_PP: fn = FN_OUT_PP;
            CONF_OUT_OD: fn = FN_OUT_OD;
            CONF_OUT_AF: fn = FN_AF_OD;
            default:     fn = FN_AF_PP;
         endcase
      end
      return fn;
   endfunction : decode_fn

   wire logic [1:0] mode = nibble_in[MODE_LSB +: FIELD_W];
   wire logic [1:0] conf = nibble_in[CONF_LSB +: FIELD_W];

   assign cfg_out.fn    = decode_fn(mode, conf);
   assign cfg_out.speed = mode;

endmodule : glpc_pin_dec

/* File: glpc_top.sv */
`timescale 1ns/10ps
module glpc_top #(
   parameter int NUM_PORTS     = glpc_pkg::NUM_PORTS,
   parameter int PINS_PER_PORT = glpc_pkg::PINS_PER_PORT
) (
   // Clock and reset
   input  wire logic                                             ref_clk_in,
   input  wire logic                                             nrst_in,
   // Register port
   input  glpc_pkg::glpc_bus_req_t                               bus_req_in,
   output logic [31:0]                                           rd_data_out,
   output logic                                                  addr_err_out,
   // Pin data sources and pad input
   input  wire logic [NUM_PORTS*PINS_PER_PORT-1:0]               gpio_data_in,
   input  wire logic [NUM_PORTS*PINS_PER_PORT-1:0]               af_data_in,
   input  wire logic [NUM_PORTS*PINS_PER_PORT-1:0]               pad_level_in,
   // Pad control
   output logic [NUM_PORTS*PINS_PER_PORT-1:0]                    pad_drive_out,
   output logic [NUM_PORTS*PINS_PER_PORT-1:0]                    pad_oe_out,
   output logic [NUM_PORTS*PINS_PER_PORT-1:0]                    pin_in_val_out,
   output glpc_pkg::glpc_pin_cfg_t [NUM_PORTS*PINS_PER_PORT-1:0] pin_cfg_out
);
   import glpc_pkg::*;

   localparam int NUM_PINS = NUM_PORTS * PINS_PER_PORT;

   // Pad control for one pin as {oe, drive}. Open-drain styles only ever
   // pull low, so a high data bit releases the pad instead of driving it.
   function automatic logic [1:0] pad_ctrl(input glpc_pin_fn_t fn, input logic gpio_d, input logic af_d);
      logic [1:0] ctl;
      ctl = 2'h0;
      case (fn)
         FN_OUT_PP: ctl = {1'b1, gpio_d};
         FN_OUT_OD: ctl = {~gpio_d, 1'b0};
         FN_AF_OD:  ctl = {~af_d, 1'b0};
         FN_AF_PP:  ctl = {1'b1, af_d};
         default:   ctl = 2'h0;
      endcase
      return ctl;
   endfunction : pad_ctrl

   logic [31:0]                 cfg      [NUM_PORTS];
   logic [31:0]                 next_cfg [NUM_PORTS];
   wire logic [NUM_PORTS-1:0]   port_hit;
   wire logic                   alt_hit;
   wire logic                   any_hit  = |port_hit;
   wire logic                   any_req  = bus_req_in.wr | bus_req_in.rd;
   logic [31:0]                 rd_mux;
   wire logic [31:0]            next_rd_data;
   wire logic                   next_addr_err;
   glpc_pin_cfg_t [NUM_PINS-1:0] dec_cfg;
   logic [NUM_PINS-1:0]         next_oe;
   logic [NUM_PINS-1:0]         next_drive;
   wire logic [NUM_PINS-1:0]    next_in_val;

   glpc_addr_dec #(
      .NUM_PORTS    (NUM_PORTS)
   ) u_addr_dec (
      .addr_in      (bus_req_in.addr),
      .port_hit_out (port_hit),
      .alt_hit_out  (alt_hit)
   );

   // Register file: one control word per port.
   for (genvar p = 0; p < NUM_PORTS; p++) begin : g_reg
      assign next_cfg[p] = (bus_req_in.wr && port_hit[p]) ? bus_req_in.wdata : cfg[p];

      always_ff @(posedge ref_clk_in or negedge nrst_in) begin
         if (!nrst_in) begin
            cfg[p] <= CFG_LOW_RST;
         end else begin
            cfg[p] <= next_cfg[p];
         end
      end
   end

   // Reads of the alternate-function window return zero here; its registers
   // live elsewhere, and only truly unmapped accesses raise the error pulse.
   always_comb begin
      rd_mux = '0;
      for (int p = 0; p < NUM_PORTS; p++) begin
         if (port_hit[p]) begin
            rd_mux = rd_mux | cfg[p];
         end
      end
   end

   assign next_rd_data  = bus_req_in.rd ? rd_mux : '0;
   assign next_addr_err = any_req && !any_hit && !alt_hit;

   always_ff @(posedge ref_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         rd_data_out  <= '0;
         addr_err_out <= 1'b0;
      end else begin
         rd_data_out  <= next_rd_data;
         addr_err_out <= next_addr_err;
      end
   end

   // Decoding from the next register value lets the pads follow a write on
   // the same edge that stores it, while every output stays registered.
   for (genvar g = 0; g < NUM_PINS; g++) begin : g_pin
      glpc_pin_dec u_pin_dec (
         .nibble_in (next_cfg[g / PINS_PER_PORT][(g % PINS_PER_PORT) * NIBBLE_W +: NIBBLE_W]),
         .cfg_out   (dec_cfg[g])
      );

      assign {next_oe[g], next_drive[g]} = pad_ctrl(dec_cfg[g].fn, gpio_data_in[g], af_data_in[g]);
      assign next_in_val[g] = (dec_cfg[g].fn != FN_ANALOG) & pad_level_in[g];
   end

   always_ff @(posedge ref_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         pad_oe_out     <= '0;
         pad_drive_out  <= '0;
         pin_in_val_out <= '0;
         pin_cfg_out    <= {NUM_PINS{PIN_RST_CFG}};
      end else begin
         pad_oe_out     <= next_oe;
         pad_drive_out  <= next_drive;
         pin_in_val_out <= next_in_val;
         pin_cfg_out    <= dec_cfg;
      end
   end

   // Checks on port A pin 0, port A pin 7 and port B.
   default clocking cb @(posedge ref_clk_in);
   endclocking
   default disable iff (!nrst_in);

   wire logic [1:0] p0_mode = cfg[0][MODE_LSB +: FIELD_W];
   wire logic [1:0] p0_conf = cfg[0][CONF_LSB +: FIELD_W];

   sequence s_wr_port_b;
      bus_req_in.wr && (bus_req_in.addr == PORT_B_BASE);
   endsequence

   sequence s_wr_none;
      !(bus_req_in.wr && any_hit);
   endsequence

   sequence s_rd_port_a;
      bus_req_in.rd && (bus_req_in.addr == PORT_A_BASE);
   endsequence

   port_b_write_a: assert property (
      s_wr_port_b |=> (cfg[1] == $past(bus_req_in.wdata)))
      else $error("Write to port B base did not land in port B register.");

   port_a_read_a: assert property (
      s_rd_port_a |=> (rd_data_out == cfg[0]) ##1 ($past(bus_req_in.rd) || (rd_data_out == '0)))
      else $error("Port A read data wrong or held too long.");

   rd_idle_zero_a: assert property (
      !bus_req_in.rd |=> (rd_data_out == '0))
      else $error("Read data present without a read.");

   hw_hold_a: assert property (
      s_wr_none |=> (cfg[0] == $past(cfg[0])) && (cfg[1] == $past(cfg[1])))
      else $error("Control word changed without a software write.");

   input_no_drive_a: assert property (
      (p0_mode == MODE_INPUT) |-> !pad_oe_out[0] && !pad_drive_out[0] && (pin_cfg_out[0].speed == MODE_INPUT))
      else $error("Pin in input mode is driving its pad.");

   analog_off_a: assert property (
      (p0_mode == MODE_INPUT) && (p0_conf == CONF_IN_ANALOG) |->
         (pin_cfg_out[0].fn == FN_ANALOG) && !pin_in_val_out[0])
      else $error("Analog pin shows a digital input value.");

   push_pull_a: assert property (
      (p0_mode != MODE_INPUT) && (p0_conf == CONF_OUT_PP) |->
         pad_oe_out[0] && (pad_drive_out[0] == $past(gpio_data_in[0])))
      else $error("Push-pull pin not driving its output data.");

   open_drain_a: assert property (
      (p0_mode != MODE_INPUT) && (p0_conf == CONF_OUT_OD) |->
         !pad_drive_out[0] && (pad_oe_out[0] == !$past(gpio_data_in[0])))
      else $error("Open-drain pin drives high or releases on low data.");

   af_code3_a: assert property (
      (p0_mode != MODE_INPUT) && (p0_conf == 2'h3) |->
         (pin_cfg_out[0].fn == FN_AF_PP) && (pad_drive_out[0] == $past(af_data_in[0])))
      else $error("Output code 11 not routed to the alternate function.");

   pin7_field_a: assert property (
      (cfg[0][31:28] == 4'h4) |-> (pin_cfg_out[7].fn == FN_IN_FLOAT) && (pin_cfg_out[7].speed == MODE_INPUT))
      else $error("Pin 7 nibble decoded from the wrong bits.");

   same_cycle_a: assert property (
      bus_req_in.wr && port_hit[0] && (bus_req_in.wdata[3:0] == 4'h3) |=>
         (pin_cfg_out[0].fn == FN_OUT_PP) && (pin_cfg_out[0].speed == MODE_OUT_50M) && pad_oe_out[0])
      else $error("Pin 0 did not follow a write in the next cycle.");

   // Wider checks on port A pins 0 and 7, port B pin 0, the last port and the register map. The
   // map is worked out from bases and stride on its own, so a slip in the
   // address decoder cannot agree with itself here.
   wire logic [1:0]  b0_mode  = cfg[1][MODE_LSB +: FIELD_W];
   wire logic [1:0]  b0_conf  = cfg[1][CONF_LSB +: FIELD_W];
   wire logic [31:0] port_rel = bus_req_in.addr - PORT_A_BASE;
   wire logic [31:0] alt_ofs  = bus_req_in.addr - ALT_FN_BASE;
   wire logic        in_span  = port_rel < PORT_STRIDE * 32'(NUM_PORTS);
   wire logic        in_ports = in_span && ((port_rel % PORT_STRIDE) == CFG_LOW_OFS);
   wire logic        in_alt   = alt_ofs < ALT_FN_SPAN;
   wire logic        bad_req  = any_req && !in_ports && !in_alt;

   sequence s_rd_port_b;
      bus_req_in.rd && (bus_req_in.addr == PORT_B_BASE);
   endsequence

   sequence s_wr_last_port;
      bus_req_in.wr && (bus_req_in.addr == PORT_A_BASE + PORT_STRIDE * 32'(NUM_PORTS - 1));
   endsequence

   sequence s_wr_ofs_four;
      bus_req_in.wr && (bus_req_in.addr == PORT_A_BASE + 32'h0000_0004);
   endsequence

   sequence s_alt_req;
      any_req && in_alt;
   endsequence

   pull_input_a: assert property (
      (p0_mode == MODE_INPUT) && (p0_conf == CONF_IN_PULL) |->
         (pin_cfg_out[0].fn == FN_IN_PULL) && !pad_oe_out[0] && (pin_in_val_out[0] == $past(pad_level_in[0])))
      else $error("Pulled input pin decoded or sampled wrongly.");

   float_input_a: assert property (
      (p0_mode == MODE_INPUT) && (p0_conf == CONF_IN_FLOAT) |->
         (pin_cfg_out[0].fn == FN_IN_FLOAT) && !pad_oe_out[0] && !pad_drive_out[0])
      else $error("Floating input pin decoded wrongly or driving.");

   reserved_input_a: assert property (
      (p0_mode == MODE_INPUT) && (p0_conf == 2'h3) |-> (pin_cfg_out[0].fn == FN_IN_RSVD) && !pad_oe_out[0])
      else $error("Reserved input code not shown as reserved or driving.");

   af_od_a: assert property (
      (p0_mode != MODE_INPUT) && (p0_conf == CONF_OUT_AF) |->
         (pin_cfg_out[0].fn == FN_AF_OD) && !pad_drive_out[0] && (pad_oe_out[0] == !$past(af_data_in[0])))
      else $error("Alternate open-drain pin drives high or ignores its data.");

   speed_pin0_a: assert property (
      pin_cfg_out[0].speed == p0_mode)
      else $error("Pin 0 speed does not follow its mode bits.");

   port_b_pp_a: assert property (
      (b0_mode != MODE_INPUT) && (b0_conf == CONF_OUT_PP) |->
         (pin_cfg_out[PINS_PER_PORT].fn == FN_OUT_PP) && pad_oe_out[PINS_PER_PORT] &&
         (pad_drive_out[PINS_PER_PORT] == $past(gpio_data_in[PINS_PER_PORT])))
      else $error("Port B pin 0 not driven from its own control word.");

   port_b_speed_a: assert property (
      pin_cfg_out[PINS_PER_PORT].speed == b0_mode)
      else $error("Port B pin 0 speed does not follow its mode bits.");

   port_b_input_a: assert property (
      (b0_mode == MODE_INPUT) |-> !pad_oe_out[PINS_PER_PORT] && !pad_drive_out[PINS_PER_PORT])
      else $error("Port B pin 0 drives its pad in input mode.");

   pin7_out_a: assert property (
      (cfg[0][29:28] != MODE_INPUT) && (cfg[0][31:30] == CONF_OUT_PP) |->
         (pin_cfg_out[7].fn == FN_OUT_PP) && (pin_cfg_out[7].speed == cfg[0][29:28]))
      else $error("Pin 7 output decoded from the wrong bits.");

   addr_err_set_a: assert property (
      bad_req |=> addr_err_out)
      else $error("Unmapped access did not raise the error pulse.");

   addr_err_clr_a: assert property (
      !bad_req |=> !addr_err_out)
      else $error("Error pulse without an unmapped access.");

   alt_window_a: assert property (
      s_alt_req |=> !addr_err_out && (rd_data_out == '0))
      else $error("Alternate-function window answered with data or an error.");

   rd_port_b_a: assert property (
      s_rd_port_b |=> (rd_data_out == cfg[1]))
      else $error("Port B read returned the wrong word.");

   wr_last_port_a: assert property (
      s_wr_last_port |=> (cfg[NUM_PORTS-1] == $past(bus_req_in.wdata)))
      else $error("Write to the last port did not land in its register.");

   ofs_four_a: assert property (
      s_wr_ofs_four |=> (cfg[0] == $past(cfg[0])) && addr_err_out)
      else $error("Write to offset four changed port A or raised no error.");

   wr_no_data_a: assert property (
      bus_req_in.wr |=> (rd_data_out == '0))
      else $error("Write answered with read data.");

   port_a_kept_a: assert property (
      bus_req_in.wr && port_hit[1] |=> (cfg[0] == $past(cfg[0])))
      else $error("Write to port B disturbed port A.");

   cfg_out_hold_a: assert property (
      s_wr_none |=> (pin_cfg_out[7:0] == $past(pin_cfg_out[7:0])))
      else $error("Decoded pin setup changed without a software write.");

   same_cycle_b_a: assert property (
      bus_req_in.wr && port_hit[1] && (bus_req_in.wdata[3:0] == 4'h1) |=>
         (pin_cfg_out[PINS_PER_PORT].fn == FN_OUT_PP) && (pin_cfg_out[PINS_PER_PORT].speed == MODE_OUT_10M))
      else $error("Port B pin 0 did not follow a write in the next cycle.");

endmodule : glpc_top

/* File: glpc_pad_model.sv */
`timescale 1ns/10ps
module glpc_pad_model #(
   parameter int N = 40
) (
   // Pad control from the port
   input  wire logic [N-1:0] pad_drive_in,
   input  wire logic [N-1:0] pad_oe_in,
   // Board resistor level per pin
   input  wire logic [N-1:0] pull_level_in,
   // Level seen at the pins
   output wire logic [N-1:0] pad_level_out
);
   // A released pin settles to its resistor level, never to the last value driven.
   assign pad_level_out = (pad_oe_in & pad_drive_in) | (~pad_oe_in & pull_level_in);
endmodule : glpc_pad_model

/* File: tb_top.sv */
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin compares++; if ((ex) !== (got)) begin fail_count++; \
   $display("mismatch %s expected %h seen %h", nm, ex, got); end end
module tb_top;
   import glpc_pkg::*;
   localparam int N = NUM_PORTS * PINS_PER_PORT;
   logic                  ref_clk_in;
   logic                  nrst_in;
   glpc_bus_req_t         bus_req;
   logic [31:0]           rd_data;
   logic                  addr_err;
   logic [N-1:0]          gpio_data, af_data, pad_level, pad_drive, pad_oe, in_val, pull_level;
   glpc_pin_cfg_t [N-1:0] pin_cfg;
   logic [32:0]           exp_q[$];
   logic [31:0]           regs[NUM_PORTS];
   logic [63:0]           r64;
   logic                  req_seen;
   int                    fail_count, compares, cycles;
   int                    seed = 32'hb2c7;

   glpc_top glpc_top_i (.ref_clk_in(ref_clk_in), .nrst_in(nrst_in), .bus_req_in(bus_req),
      .rd_data_out(rd_data), .addr_err_out(addr_err), .gpio_data_in(gpio_data), .af_data_in(af_data),
      .pad_level_in(pad_level), .pad_drive_out(pad_drive), .pad_oe_out(pad_oe),
      .pin_in_val_out(in_val), .pin_cfg_out(pin_cfg));
   glpc_pad_model #(.N(N)) glpc_pad_model_i (.pad_drive_in(pad_drive), .pad_oe_in(pad_oe),
      .pull_level_in(pull_level), .pad_level_out(pad_level));

   initial begin
      ref_clk_in = 1'b0;
      forever #10 ref_clk_in = ~ref_clk_in;
   end

   task automatic final_report;
      if (fail_count == 0 && compares > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : final_report

   // Every request leaves a note; the answer cycle after it takes the oldest one.
   always @(posedge ref_clk_in) begin
      if (req_seen && exp_q.size() > 0) begin
         `CHK("error and read word", exp_q[0], {addr_err, rd_data})
         void'(exp_q.pop_front());
      end
      req_seen <= bus_req.wr | bus_req.rd;
      cycles++;
      if (cycles == 5000) begin
         fail_count++;
         final_report();
      end
   end

   function automatic logic [31:0] port_addr(input int p);
      return PORT_A_BASE + 32'(p) * PORT_STRIDE;
   endfunction : port_addr

   task automatic op(input logic w, input logic [31:0] a, input logic [31:0] d, input logic [32:0] ex);
      exp_q.push_back(ex);
      @(posedge ref_clk_in);
      bus_req <= '{addr: a, wdata: d, wr: w, rd: ~w};
   endtask : op

   task automatic idle;
      @(posedge ref_clk_in);
      bus_req.wr <= 1'b0;
      bus_req.rd <= 1'b0;
   endtask : idle

   task automatic read_ports;
      for (int p = 0; p < NUM_PORTS; p++) op(1'b0, port_addr(p), 32'h0000_0000, {1'b0, regs[p]});
   endtask : read_ports

   task automatic chk_pins(input bit with_in);
      glpc_pin_fn_t e;
      logic [3:0]   nb;
      logic         o, d;
      for (int g = 0; g < N; g++) begin
         nb = regs[g / 8][4 * (g % 8) +: 4];
         case ({nb[1:0] != 2'h0, nb[3:2]})
            3'h0: e = FN_ANALOG;
            3'h1: e = FN_IN_FLOAT;
            3'h2: e = FN_IN_PULL;
            3'h3: e = FN_IN_RSVD;
            3'h4: e = FN_OUT_PP;
            3'h5: e = FN_OUT_OD;
            3'h6: e = FN_AF_OD;
            default: e = FN_AF_PP;
         endcase
         o = (e == FN_OUT_PP || e == FN_AF_PP) ? 1'b1 : (e == FN_OUT_OD) ? ~gpio_data[g] :
             (e == FN_AF_OD) ? ~af_data[g] : 1'b0;
         d = (e == FN_OUT_PP) ? gpio_data[g] : (e == FN_AF_PP) ? af_data[g] : 1'b0;
         `CHK("pin function", e, pin_cfg[g].fn)
         `CHK("pin speed", nb[1:0], pin_cfg[g].speed)
         `CHK("pad enable and drive", {o, d}, {pad_oe[g], pad_drive[g]})
         if (with_in) `CHK("input value", (e == FN_ANALOG) ? 1'b0 : pad_level[g], in_val[g])
      end
   endtask : chk_pins

   task automatic reset_run;
      nrst_in <= 1'b0;
      repeat (12) @(posedge ref_clk_in);
      nrst_in <= 1'b1;
      for (int p = 0; p < NUM_PORTS; p++) regs[p] = CFG_LOW_RST;
      read_ports();
      idle();
      @(negedge ref_clk_in);
      chk_pins(1'b1);
   endtask : reset_run

   initial begin
      logic [31:0] w;
      nrst_in = 1'b0;
      bus_req = '0;
      gpio_data = '0;
      af_data = '0;
      pull_level = '0;
      fail_count = 0;
      compares = 0;
      cycles = 0;
      reset_run();
      for (int c = 0; c < 16; c++) begin
         @(posedge ref_clk_in);
         r64 = {$random(seed), $random(seed)};
         gpio_data <= r64[N-1:0];
         r64 = {$random(seed), $random(seed)};
         af_data <= r64[N-1:0];
         pull_level <= r64[63:64-N];
         for (int p = 0; p < NUM_PORTS; p++) begin
            for (int k = 0; k < 8; k++) w[4 * k +: 4] = 4'(c + k + p);
            regs[p] = w;
            op(1'b1, port_addr(p), w, 33'h0_0000_0000);
         end
         idle();
         @(negedge ref_clk_in);
         chk_pins(1'b0);
         repeat (2) @(posedge ref_clk_in);
         @(negedge ref_clk_in);
         chk_pins(1'b1);
         op(1'b0, port_addr(c % NUM_PORTS), 32'h0000_0000, {1'b0, regs[c % NUM_PORTS]});
         idle();
      end
      // Refused places must neither disturb any register nor answer with data.
      op(1'b1, ALT_FN_BASE, 32'hFFFF_FFFF, 33'h0_0000_0000);
      op(1'b1, 32'h4001_0804, 32'hFFFF_FFFF, 33'h1_0000_0000);
      op(1'b1, 32'h4001_1C00, 32'hFFFF_FFFF, 33'h1_0000_0000);
      op(1'b0, 32'h4001_0010, 32'h0000_0000, 33'h0_0000_0000);
      op(1'b0, 32'h4001_0804, 32'h0000_0000, 33'h1_0000_0000);
      read_ports();
      idle();
      repeat (3) @(posedge ref_clk_in);
      reset_run();
      repeat (3) @(posedge ref_clk_in);
      final_report();
   end
endmodule : tb_top
